//--- rtl/dsp_serial_port.sv
// Two-wire serial port: master sequencer, byte engine, flags and registers
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_port #(
  parameter int unsigned DIV_BASE = dsp_pkg::DIV_BASE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [dsp_pkg::AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Two-wire bus, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Stream clock pin
  input wire logic vsync_i
);
  localparam int unsigned CW = $clog2(DIV_BASE * 64);

  if (DIV_BASE < 16 || (DIV_BASE % 2) != 0) begin : g_chk
    $error("DIV_BASE must be even and at least 16");
  end

  function automatic logic hit(input logic [dsp_pkg::AW-1:0] a,
                               input logic [dsp_pkg::AW-1:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic addr_match(input logic [7:0] b, input logic [7:0] own);
    if (own[0]) begin
      return (b[7:1] == 7'h00) || (b[7:4] == own[7:4]);
    end
    return b[7:1] == own[7:1];
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers and line events
  // ------------------------------------------------------------
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 3'h3;
      s2_q <= 3'h3;
      s3_q <= 3'h3;
    end else begin
      s1_q <= {vsync_i, sda_i, scl_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, vs_rise, start_det, stop_det;
  assign scl_s = s2_q[0];
  assign sda_s = s2_q[1];
  assign scl_rise = scl_s & ~s3_q[0];
  assign scl_fall = ~scl_s & s3_q[0];
  assign vs_rise = s2_q[2] & ~s3_q[2];
  assign start_det = scl_s & s3_q[0] & ~sda_s & s3_q[1];
  assign stop_det = scl_s & s3_q[0] & sda_s & ~s3_q[1];

  // ------------------------------------------------------------
  // Software configuration
  // ------------------------------------------------------------
  logic [7:0] own_q;
  logic [7:0] ctrl_q;
  logic mdir_q;
  logic [dsp_pkg::RATE_W-1:0] rate_q;
  logic wr_own, wr_ctrl, wr_mctl, wr_st, wr_tx, rd_rx;
  logic en, acks, vs, en_rise;

  assign wr_own = reg_wr & hit(reg_addr, dsp_pkg::OFS_OWN);
  assign wr_ctrl = reg_wr & hit(reg_addr, dsp_pkg::OFS_CTRL);
  assign wr_mctl = reg_wr & hit(reg_addr, dsp_pkg::OFS_MCTL);
  assign wr_st = reg_wr & hit(reg_addr, dsp_pkg::OFS_STAT);
  assign en = ctrl_q[dsp_pkg::CTL_EN];
  assign acks = ctrl_q[dsp_pkg::CTL_ACKS];
  assign vs = ctrl_q[dsp_pkg::CTL_VS];
  // A holding write while disabled is dropped
  assign wr_tx = reg_wr & hit(reg_addr, dsp_pkg::OFS_TXH) & en;
  assign rd_rx = reg_rd & hit(reg_addr, dsp_pkg::OFS_RXH) & en;
  assign en_rise = wr_ctrl & reg_wdata[dsp_pkg::CTL_EN] & ~en;

  always_ff @(posedge clk) begin
    if (rst) begin
      own_q <= dsp_pkg::OWN_RST;
      ctrl_q <= '0;
      mdir_q <= 1'b0;
      rate_q <= '0;
    end else begin
      if (wr_own) begin
        own_q <= reg_wdata;
      end
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata & dsp_pkg::CTRL_MASK;
      end
      if (wr_mctl) begin
        mdir_q <= reg_wdata[dsp_pkg::MC_DIR];
        rate_q <= reg_wdata[dsp_pkg::MC_RATE +: dsp_pkg::RATE_W];
      end
    end
  end

  // ------------------------------------------------------------
  // Master control flags
  // ------------------------------------------------------------
  logic mreq_q, arb_q, nak_q, busy_q;
  logic arb_ev, nak_ev, mst_act, tx_like, rx_like;
  dsp_pkg::dsp_mst_t mst_q;
  dsp_pkg::dsp_eng_t eng_q;
  logic [3:0] bitn_q;
  logic eng_sda_q;

  assign mst_act = mst_q != dsp_pkg::M_IDLE;
  assign tx_like = (eng_q == dsp_pkg::E_MADDR) || (eng_q == dsp_pkg::E_TX);
  assign rx_like = (eng_q == dsp_pkg::E_SADDR) || (eng_q == dsp_pkg::E_RX);
  // Released SDA read back low while we send: another master won
  assign arb_ev = mst_act & tx_like & scl_rise & (bitn_q < dsp_pkg::BIT_ACK)
                  & ~eng_sda_q & ~sda_s;
  assign nak_ev = mst_act & tx_like & scl_rise & (bitn_q == dsp_pkg::BIT_ACK)
                  & sda_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      mreq_q <= 1'b0;
      arb_q <= 1'b0;
      nak_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (wr_mctl) begin
        // A fresh request on a busy bus is refused
        mreq_q <= reg_wdata[dsp_pkg::MC_REQ] & (mreq_q | ~busy_q) & en;
        if (!reg_wdata[dsp_pkg::MC_ARB]) begin
          arb_q <= 1'b0;
        end
        if (!reg_wdata[dsp_pkg::MC_NAK]) begin
          nak_q <= 1'b0;
        end
        if (reg_wdata[dsp_pkg::MC_REQ] && !mreq_q && busy_q) begin
          arb_q <= 1'b1;
        end
      end
      if (arb_ev) begin
        arb_q <= 1'b1;
        mreq_q <= 1'b0;
      end
      if (nak_ev) begin
        nak_q <= 1'b1;
        mreq_q <= 1'b0;
      end
      if (!en) begin
        mreq_q <= 1'b0;
      end
      if (start_det) begin
        busy_q <= 1'b1;
      end else if (stop_det || (en_rise && reg_wdata[dsp_pkg::CTL_VS])) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Master clock and start/stop sequencer
  // ------------------------------------------------------------
  logic [CW-1:0] mcnt_q;
  logic [CW-1:0] half_lim;
  logic stop_req_q;
  logic mst_scl, mst_sda;

  assign half_lim = CW'(((DIV_BASE / 2) << rate_q) - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      mst_q <= dsp_pkg::M_IDLE;
      mcnt_q <= '0;
    end else if (!en || arb_ev) begin
      mst_q <= dsp_pkg::M_IDLE;
      mcnt_q <= '0;
    end else begin
      mcnt_q <= mcnt_q + CW'(1);
      unique case (mst_q)
        dsp_pkg::M_IDLE: begin
          mcnt_q <= '0;
          if (mreq_q && !busy_q) begin
            mst_q <= dsp_pkg::M_START;
          end
        end
        dsp_pkg::M_START, dsp_pkg::M_LOW: begin
          if (mcnt_q == half_lim) begin
            mst_q <= dsp_pkg::M_HIGH;
            if (mst_q == dsp_pkg::M_START) begin
              mst_q <= dsp_pkg::M_LOW;
            end
            mcnt_q <= '0;
          end
        end
        dsp_pkg::M_HIGH: begin
          // High time counts only once the line is really high
          if (!scl_s) begin
            mcnt_q <= '0;
          end else if (mcnt_q == half_lim) begin
            mst_q <= stop_req_q ? dsp_pkg::M_STOP_LOW : dsp_pkg::M_LOW;
            mcnt_q <= '0;
          end
        end
        dsp_pkg::M_STOP_LOW: begin
          if (mcnt_q == half_lim) begin
            mst_q <= dsp_pkg::M_STOP_REL;
            mcnt_q <= '0;
          end
        end
        dsp_pkg::M_STOP_REL: begin
          if (!scl_s) begin
            mcnt_q <= '0;
          end else if (mcnt_q == half_lim) begin
            mst_q <= dsp_pkg::M_IDLE;
          end
        end
      endcase
    end
  end

  assign mst_scl = (mst_q == dsp_pkg::M_LOW) || (mst_q == dsp_pkg::M_STOP_LOW);
  // SDA falls only after SCL is low, so no false start precedes the stop
  assign mst_sda = (mst_q == dsp_pkg::M_START) || (mst_q == dsp_pkg::M_STOP_REL)
                   || ((mst_q == dsp_pkg::M_STOP_LOW) && (mcnt_q >= CW'(dsp_pkg::STOP_SETUP)));

  // ------------------------------------------------------------
  // Byte engine, holding registers and status
  // ------------------------------------------------------------
  logic [7:0] sh_q, txh_q, rxh_q, pend_b_q;
  logic [7:0] rxb;
  logic stretch_q, pend_q, pend_m_q, wtx_q;
  dsp_pkg::dsp_status_t st_q;

  assign rxb = {sh_q[6:0], sda_s};

  always_ff @(posedge clk) begin
    if (rst) begin
      eng_q <= dsp_pkg::E_IDLE;
      st_q <= dsp_pkg::STAT_RST;
      sh_q <= 8'hff;
      txh_q <= 8'h00;
      rxh_q <= 8'h00;
      pend_b_q <= 8'h00;
      bitn_q <= 4'h0;
      eng_sda_q <= 1'b0;
      stretch_q <= 1'b0;
      pend_q <= 1'b0;
      pend_m_q <= 1'b0;
      wtx_q <= 1'b0;
      stop_req_q <= 1'b0;
    end else if (!en) begin
      eng_q <= dsp_pkg::E_IDLE;
      eng_sda_q <= 1'b0;
      stretch_q <= 1'b0;
      pend_q <= 1'b0;
      wtx_q <= 1'b0;
      stop_req_q <= 1'b0;
      st_q.rx_flag <= 1'b0;
      st_q.tx_flag <= 1'b0;
      st_q.clk_fall <= 1'b0;
      st_q.tx_empty <= 1'b1;
      st_q.rx_full <= 1'b0;
    end else begin
      // Software clears come first so a same-cycle hardware set wins
      if (wr_st) begin
        if (!reg_wdata[dsp_pkg::ST_RXF]) begin
          st_q.rx_flag <= 1'b0;
        end
        if (!reg_wdata[dsp_pkg::ST_TXF]) begin
          st_q.tx_flag <= 1'b0;
        end
        if (!reg_wdata[dsp_pkg::ST_SCF]) begin
          st_q.clk_fall <= 1'b0;
        end
      end
      if (!vs) begin
        st_q.clk_fall <= 1'b0;
      end else begin
        st_q.slave_dir <= 1'b1;
        if (scl_fall) begin
          st_q.clk_fall <= 1'b1;
        end
      end
      if (!mst_act) begin
        stop_req_q <= 1'b0;
      end
      if (rd_rx) begin
        st_q.rx_full <= 1'b0;
        if (pend_q) begin
          rxh_q <= pend_b_q;
          st_q.match <= pend_m_q;
          st_q.rx_full <= 1'b1;
          st_q.rx_flag <= 1'b1;
          pend_q <= 1'b0;
          stretch_q <= wtx_q;
        end
      end
      if (wr_tx) begin
        txh_q <= reg_wdata;
        st_q.tx_empty <= 1'b0;
        if (wtx_q) begin
          // Stretched waiting for data: load now and let SCL go unless a received byte is still pending
          sh_q <= reg_wdata;
          eng_sda_q <= ~reg_wdata[7];
          st_q.tx_empty <= 1'b1;
          st_q.tx_flag <= 1'b1;
          wtx_q <= 1'b0;
          stretch_q <= pend_q;
        end
      end
      // Line sequencing
      if (vs) begin
        if (eng_q != dsp_pkg::E_VS) begin
          eng_q <= dsp_pkg::E_VS;
          bitn_q <= dsp_pkg::BIT_ACK;
          eng_sda_q <= 1'b0;
          stretch_q <= 1'b0;
        end else if (vs_rise) begin
          if (bitn_q < dsp_pkg::BIT_ACK) begin
            eng_sda_q <= ~sh_q[7];
            sh_q <= {sh_q[6:0], 1'b1};
            bitn_q <= bitn_q + 4'h1;
          end else begin
            // Ninth stream bit is left released; fetch the next byte
            eng_sda_q <= 1'b0;
            bitn_q <= 4'h0;
            // A holding write in the reload cycle goes straight to the shifter
            if (wr_tx || !st_q.tx_empty) begin
              sh_q <= wr_tx ? reg_wdata : txh_q;
              st_q.tx_flag <= 1'b1;
              st_q.tx_empty <= 1'b1;
            end
          end
        end
      end else if (eng_q == dsp_pkg::E_VS) begin
        eng_q <= dsp_pkg::E_IDLE;
        eng_sda_q <= 1'b0;
      end else if (start_det) begin
        bitn_q <= 4'h0;
        stretch_q <= 1'b0;
        wtx_q <= 1'b0;
        if (mst_q == dsp_pkg::M_START) begin
          eng_q <= dsp_pkg::E_MADDR;
          sh_q <= {own_q[7:1], mdir_q};
          eng_sda_q <= 1'b1;
        end else begin
          eng_q <= dsp_pkg::E_SADDR;
          eng_sda_q <= 1'b0;
        end
      end else if (stop_det || arb_ev) begin
        eng_q <= dsp_pkg::E_IDLE;
        eng_sda_q <= 1'b0;
        stretch_q <= 1'b0;
        wtx_q <= 1'b0;
      end else if (eng_q != dsp_pkg::E_IDLE && scl_fall) begin
        if (bitn_q < dsp_pkg::BIT_ACK) begin
          eng_sda_q <= tx_like & ~sh_q[7];
        end else begin
          eng_sda_q <= rx_like & ~acks;
        end
        if (pend_q || wtx_q) begin
          stretch_q <= 1'b1;
        end
      end else if (eng_q != dsp_pkg::E_IDLE && scl_rise) begin
        if (bitn_q < dsp_pkg::BIT_ACK) begin
          sh_q <= rxb;
          bitn_q <= bitn_q + 4'h1;
          if (bitn_q == dsp_pkg::BIT_LAST && rx_like) begin
            if (eng_q == dsp_pkg::E_SADDR && !addr_match(rxb, own_q)) begin
              eng_q <= dsp_pkg::E_IDLE;
            end else begin
              if (eng_q == dsp_pkg::E_SADDR) begin
                st_q.slave_dir <= rxb[0];
              end
              // A read in the same cycle frees the holding register at once
              if (!st_q.rx_full || rd_rx) begin
                rxh_q <= rxb;
                st_q.match <= eng_q == dsp_pkg::E_SADDR;
                st_q.rx_full <= 1'b1;
                st_q.rx_flag <= 1'b1;
              end else begin
                pend_q <= 1'b1;
                pend_b_q <= rxb;
                pend_m_q <= eng_q == dsp_pkg::E_SADDR;
              end
            end
          end
        end else begin
          bitn_q <= 4'h0;
          if (tx_like) begin
            st_q.ack_n <= sda_s;
          end
          if (mst_act && (sda_s && tx_like || !mreq_q)) begin
            eng_q <= dsp_pkg::E_IDLE;
            stop_req_q <= 1'b1;
          end else if (tx_like && sda_s) begin
            eng_q <= dsp_pkg::E_IDLE;
          end else begin
            if (eng_q == dsp_pkg::E_MADDR) begin
              eng_q <= mdir_q ? dsp_pkg::E_RX : dsp_pkg::E_TX;
            end else if (eng_q == dsp_pkg::E_SADDR) begin
              eng_q <= rxb[0] ? dsp_pkg::E_TX : dsp_pkg::E_RX;
            end
            if ((eng_q == dsp_pkg::E_MADDR && !mdir_q) || eng_q == dsp_pkg::E_TX
                || (eng_q == dsp_pkg::E_SADDR && st_q.slave_dir)) begin
              if (wr_tx || !st_q.tx_empty) begin
                sh_q <= wr_tx ? reg_wdata : txh_q;
                st_q.tx_flag <= 1'b1;
                st_q.tx_empty <= 1'b1;
              end else begin
                wtx_q <= 1'b1;
              end
            end
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drivers and read port
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_oe <= mst_scl | stretch_q;
      sda_oe <= mst_sda | eng_sda_q;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          dsp_pkg::OFS_OWN: reg_rdata <= own_q;
          dsp_pkg::OFS_CTRL: reg_rdata <= ctrl_q;
          dsp_pkg::OFS_MCTL: reg_rdata <= {arb_q, nak_q, busy_q, mreq_q, mdir_q, rate_q};
          dsp_pkg::OFS_STAT: reg_rdata <= st_q;
          dsp_pkg::OFS_RXH: reg_rdata <= rxh_q;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/dsp_pkg.sv
// Package: register map, field positions, reset values and types of the display serial port
`default_nettype none
package dsp_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int unsigned AW = 5;
  localparam logic [AW-1:0] OFS_OWN = 5'h14;
  localparam logic [AW-1:0] OFS_CTRL = 5'h15;
  localparam logic [AW-1:0] OFS_MCTL = 5'h16;
  localparam logic [AW-1:0] OFS_TXH = 5'h17;
  localparam logic [AW-1:0] OFS_RXH = 5'h18;
  localparam logic [AW-1:0] OFS_STAT = 5'h19;

  // ------------------------------------------------------------
  // Reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] OWN_RST = 8'ha0;
  localparam logic [7:0] STAT_RST = 8'h0a;
  // Only enable, two interrupt enables, ack_suppress and stream enable exist
  localparam logic [7:0] CTRL_MASK = 8'hce;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned CTL_EN = 7;
  localparam int unsigned CTL_ACKS = 3;
  localparam int unsigned CTL_VS = 1;
  localparam int unsigned MC_ARB = 7;
  localparam int unsigned MC_NAK = 6;
  localparam int unsigned MC_REQ = 4;
  localparam int unsigned MC_DIR = 3;
  localparam int unsigned MC_RATE = 0;
  localparam int unsigned RATE_W = 3;
  localparam int unsigned ST_RXF = 7;
  localparam int unsigned ST_TXF = 6;
  localparam int unsigned ST_SCF = 2;

  // ------------------------------------------------------------
  // Timing and bit counting
  // ------------------------------------------------------------
  // Clock divisor for rate code 0; each code step doubles it
  localparam int unsigned DIV_BASE = 20;
  // Cycles SCL is held low before SDA is pulled for a stop
  localparam int unsigned STOP_SETUP = 2;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic rx_flag;
    logic tx_flag;
    logic match;
    logic slave_dir;
    logic ack_n;
    logic clk_fall;
    logic tx_empty;
    logic rx_full;
  } dsp_status_t;

  typedef enum logic [2:0] {
    M_IDLE, M_START, M_LOW, M_HIGH, M_STOP_LOW, M_STOP_REL
  } dsp_mst_t;

  typedef enum logic [2:0] {
    E_IDLE, E_MADDR, E_SADDR, E_TX, E_RX, E_VS
  } dsp_eng_t;
endpackage
`default_nettype wire

//--- tb/dsp_serial_port_properties.sv
// Checker: register and line properties of the display serial port
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_port_properties #(
  parameter int unsigned DIV_BASE = dsp_pkg::DIV_BASE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [dsp_pkg::AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Two-wire bus
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic vsync_i
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic en_q, mst_q, busy_q, scl_q, sda_q;
  logic [2:0] rate_q;
  int unsigned low_q;
  wire wr_ctl = reg_wr && reg_addr == dsp_pkg::OFS_CTRL;
  wire wr_mc = reg_wr && reg_addr == dsp_pkg::OFS_MCTL;
  wire rd_st = reg_rd && reg_addr == dsp_pkg::OFS_STAT;
  wire req_wr = wr_mc && reg_wdata[dsp_pkg::MC_REQ];
  wire revive = wr_ctl && !en_q && reg_wdata[dsp_pkg::CTL_EN] && reg_wdata[dsp_pkg::CTL_VS];
  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= 1'b0;
    end else if (wr_ctl) begin
      en_q <= reg_wdata[dsp_pkg::CTL_EN];
    end
  end
  // Request as last written; the design may drop it earlier on its own
  always_ff @(posedge clk) begin
    if (rst) begin
      mst_q <= 1'b0;
      rate_q <= 3'h0;
    end else if (wr_mc) begin
      mst_q <= reg_wdata[dsp_pkg::MC_REQ];
      rate_q <= reg_wdata[2:0];
    end
  end
  // Bus state seen on the wires, ahead of the design's own synchroniser
  always_ff @(posedge clk) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (rst || revive) begin
      busy_q <= 1'b0;
    end else if (scl_i && scl_q && sda_q != sda_i) begin
      busy_q <= sda_q;
    end
  end
  always_ff @(posedge clk) begin
    low_q <= scl_oe ? low_q + 1 : 0;
  end
  chk_never_high: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  chk_status_reset: assert property ($past(rst) && rd_st |=> reg_rdata == dsp_pkg::STAT_RST)
    else $error("status reset value");
  chk_tx_empty_off: assert property (!en_q && rd_st |=> reg_rdata[1])
    else $error("tx empty not forced");
  chk_flag_clear: assert property (reg_wr && reg_addr == dsp_pkg::OFS_STAT
    && !reg_wdata[dsp_pkg::ST_TXF] ##2 rd_st |=> !reg_rdata[dsp_pkg::ST_TXF])
    else $error("tx flag not cleared");
  chk_start_cond: assert property (req_wr && !busy_q && en_q && !scl_oe
    |=> ##2 sda_oe && !scl_oe)
    else $error("no start");
  chk_busy_refuse: assert property (req_wr && busy_q && !mst_q
    |=> (!scl_oe && !sda_oe)[*8])
    else $error("busy bus taken");
  chk_half_low: assert property ($fell(scl_oe) && mst_q && rate_q == 3'h0
    |-> low_q == DIV_BASE / 2)
    else $error("low half period");
  chk_rd_gap: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside slot");
  cov_start: cover property ($rose(sda_oe) && !scl_oe);
  cov_refuse: cover property (req_wr && busy_q);
  cov_stop: cover property ($fell(busy_q));
endmodule
bind dsp_serial_port dsp_serial_port_properties #(.DIV_BASE(DIV_BASE)) i_dsp_serial_port_properties (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .vsync_i(vsync_i));
`default_nettype wire

//--- tb/dsp_far_slave.sv
// Far-end slave: acknowledges bytes on command and records the last byte seen
`timescale 1ns/1ps
`default_nettype none
module dsp_far_slave (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Acknowledge on command
  input wire logic ack_en,
  output logic sda_pull,
  output logic [7:0] last_byte
);
  int unsigned nbits = 0;
  logic [7:0] shift_q = 8'h00;
  initial sda_pull = 1'b0;
  initial last_byte = 8'h00;
  // A start or repeated start realigns the byte count
  always @(negedge sda) if (scl) nbits = 0;
  always @(negedge scl) begin
    nbits = (nbits == 9) ? 1 : nbits + 1;
    sda_pull <= ack_en && nbits == 9;
  end
  always @(posedge scl) begin
    shift_q = {shift_q[6:0], sda};
    if (nbits == 8) last_byte = shift_q;
  end
endmodule
`default_nettype wire

//--- tb/tb_dsp_serial_port.sv
// Testbench: register-level tests of the display serial port with a far-end slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_dsp_serial_port;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [dsp_pkg::AW-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic vsync = 1'b0;
  logic ack_en = 1'b1;
  logic tb_pull = 1'b0;
  logic tb_scl = 1'b0;
  logic [7:0] reg_rdata, last_byte;
  logic scl_o, scl_oe, sda_o, sda_oe, slave_pull;
  int fails = 0;
  int checked = 0;
  wire scl_line = !(scl_oe || tb_scl);
  wire sda_line = !(sda_oe || slave_pull || tb_pull);
  always #5 clk = ~clk;
  dsp_serial_port #(.DIV_BASE(16)) i_dsp_serial_port (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .vsync_i(vsync));
  dsp_far_slave i_dsp_far_slave (.scl(scl_line), .sda(sda_line), .ack_en(ack_en),
    .sda_pull(slave_pull), .last_byte(last_byte));
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Let an edge pass so the next call never reassigns a strobe in this step
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Read data stand until this edge; taken before it is replaced
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic exp_rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  // Polls one bit; a bit that never arrives ends as a mismatch
  task automatic poll(input logic [4:0] a, input int b, input logic v);
    logic [7:0] d;
    int n;
    n = 0;
    rd(a, d);
    while (d[b] !== v && n < 3000) begin
      n++;
      rd(a, d);
    end
    `CHK(d[b], v)
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // -------------------------------------------------------------
    // Reset values and places that cannot be written or read
    // -------------------------------------------------------------
    exp_rd(dsp_pkg::OFS_STAT, dsp_pkg::STAT_RST);
    exp_rd(dsp_pkg::OFS_MCTL, 8'h00);
    exp_rd(dsp_pkg::OFS_OWN, dsp_pkg::OWN_RST);
    exp_rd(dsp_pkg::OFS_TXH, 8'h00);
    exp_rd(5'h1f, 8'h00);
    wr(dsp_pkg::OFS_RXH, 8'h5a);
    exp_rd(dsp_pkg::OFS_RXH, 8'h00);
    wr(dsp_pkg::OFS_TXH, 8'h33);
    exp_rd(dsp_pkg::OFS_STAT, 8'h0a);
    wr(dsp_pkg::OFS_CTRL, 8'h80);
    wr(dsp_pkg::OFS_TXH, 8'h55);
    exp_rd(dsp_pkg::OFS_STAT, 8'h08);
    // -------------------------------------------------------------
    // Master write, stop requested while the data byte is in flight
    // -------------------------------------------------------------
    wr(dsp_pkg::OFS_MCTL, 8'h10);
    poll(dsp_pkg::OFS_MCTL, 5, 1'b1);
    poll(dsp_pkg::OFS_STAT, dsp_pkg::ST_TXF, 1'b1);
    exp_rd(dsp_pkg::OFS_STAT, 8'h42);
    wr(dsp_pkg::OFS_MCTL, 8'h00);
    poll(dsp_pkg::OFS_MCTL, 5, 1'b0);
    exp_rd(dsp_pkg::OFS_MCTL, 8'h00);
    `CHK(last_byte, 8'h55)
    wr(dsp_pkg::OFS_STAT, 8'h00);
    exp_rd(dsp_pkg::OFS_STAT, 8'h02);
    // -------------------------------------------------------------
    // Read address not acknowledged: pending byte must stay put
    // -------------------------------------------------------------
    ack_en <= 1'b0;
    wr(dsp_pkg::OFS_TXH, 8'h0f);
    wr(dsp_pkg::OFS_MCTL, 8'h19);
    poll(dsp_pkg::OFS_MCTL, dsp_pkg::MC_NAK, 1'b1);
    poll(dsp_pkg::OFS_MCTL, 5, 1'b0);
    exp_rd(dsp_pkg::OFS_MCTL, 8'h49);
    `CHK(last_byte, 8'ha1)
    exp_rd(dsp_pkg::OFS_STAT, 8'h08);
    wr(dsp_pkg::OFS_MCTL, 8'h00);
    exp_rd(dsp_pkg::OFS_MCTL, 8'h00);
    // -------------------------------------------------------------
    // Foreign start: request refused, then hang recovery
    // -------------------------------------------------------------
    tb_pull <= 1'b1;
    poll(dsp_pkg::OFS_MCTL, 5, 1'b1);
    wr(dsp_pkg::OFS_MCTL, 8'h10);
    exp_rd(dsp_pkg::OFS_MCTL, 8'ha0);
    wr(dsp_pkg::OFS_MCTL, 8'h00);
    exp_rd(dsp_pkg::OFS_MCTL, 8'h20);
    wr(dsp_pkg::OFS_CTRL, 8'h00);
    wr(dsp_pkg::OFS_CTRL, 8'h82);
    exp_rd(dsp_pkg::OFS_MCTL, 8'h00);
    poll(dsp_pkg::OFS_STAT, 4, 1'b1);
    tb_scl <= 1'b1;
    poll(dsp_pkg::OFS_STAT, dsp_pkg::ST_SCF, 1'b1);
    tb_scl <= 1'b0;
    wr(dsp_pkg::OFS_STAT, 8'h00);
    exp_rd(dsp_pkg::OFS_STAT, 8'h1a);
    wr(dsp_pkg::OFS_TXH, 8'h3c);
    exp_rd(dsp_pkg::OFS_STAT, 8'h18);
    vsync <= 1'b1;
    poll(dsp_pkg::OFS_STAT, dsp_pkg::ST_TXF, 1'b1);
    exp_rd(dsp_pkg::OFS_STAT, 8'h5a);
    wr(dsp_pkg::OFS_TXH, 8'h3c);
    tb_pull <= 1'b0;
    wr(dsp_pkg::OFS_CTRL, 8'h00);
    poll(dsp_pkg::OFS_STAT, 1, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
